// [rtl/fault_response.sv]
`timescale 1ns/1ns

// Overview of operation
// - Lock current over threshold, codes 0-3: Hi-Z or brake, latched.
// - Lock codes 4-7: Hi-Z or brake, then retry after lock retry time.
// - Position-detect ramp over 500 ms: if enabled Hi-Z, report, retry.
// - Pulse before previous current decayed: if enabled Hi-Z, report, retry.
// - Measurement timeout or low back-EMF: Hi-Z, latched until clear.
// - Supply above nonzero upper limit: Hi-Z; latch or recover 1 V below.
// - Supply below nonzero lower limit: Hi-Z; latch or recover 0.5 V above.
// - Missed host watchdog tickle reports; action 1 also Hi-Z, latched.
// - Latched faults release only after clear command and condition gone.
module fault_response import fault_response_pkg::*; #(
    parameter logic [TIMER_W-1:0] IPD_TIMEOUT_CYCLES =
        msToCycles(IPD_TIMEOUT_MS),
    parameter logic [TIMER_W-1:0] LOCK_RETRY_CYCLES =
        msToCycles(LOCK_RETRY_MS),
    parameter logic [TIMER_W-1:0] WDT_CYCLES = msToCycles(WDT_INTERVAL_MS)
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic [11:0]           sensedCurrentVoltage,
    input  wire logic [11:0]           softLockCurrentThreshold,
    input  wire logic [3:0]            softLockLimitAction,
    input  wire logic                  positionDetectRampUp,
    input  wire logic                  positionDetectRampDown,
    input  wire logic                  positionDetectTimeoutEnable,
    input  wire logic                  positionDetectPulseStart,
    input  wire logic                  positionDetectCurrentDecayed,
    input  wire logic                  positionDetectRateEnable,
    input  wire logic                  measureRlActive,
    input  wire logic                  measureRlTimeout,
    input  wire logic                  measureBackemfActive,
    input  wire logic [11:0]           backemfLevel,
    input  wire logic [11:0]           stationaryDetectThreshold,
    input  wire logic [7:0]            supplyVoltage,
    input  wire logic [2:0]            supplyUpperLimit,
    input  wire logic                  supplyOverRecoveryMode,
    input  wire logic [2:0]            supplyLowerLimit,
    input  wire logic                  supplyUnderRecoveryMode,
    input  wire logic                  hostWatchdogEnable,
    input  wire logic                  hostWatchdogAction,
    input  wire logic                  hostWatchdogTickle,
    input  wire logic                  faultClearCommand,
    output logic                       faultPinLowActive,
    output bridge_t                    bridgeMode,
    output logic [NUM_FAULTS-1:0]      controllerFaultStatus
);

    logic [1:0]            tickleSync;
    logic [1:0]            next_tickleSync;
    logic                  tickleLast;
    logic                  tickleEdge;
    logic                  ipdExpired;
    logic                  wdtExpired;
    logic                  retryExpired;
    logic [7:0]            upperLevel;
    logic [7:0]            lowerLevel;
    logic [NUM_FAULTS-1:0] cond;
    logic [NUM_FAULTS-1:0] trig;
    logic [NUM_FAULTS-1:0] recovered;
    logic [NUM_FAULTS-1:0] retryMask;
    logic [NUM_FAULTS-1:0] autoMask;
    logic [NUM_FAULTS-1:0] release_;
    bridge_t               act [NUM_FAULTS];
    logic [NUM_FAULTS-1:0] engaged;
    logic [NUM_FAULTS-1:0] next_engaged;
    logic [NUM_FAULTS-1:0] next_status;
    bridge_t               next_bridgeMode;
    logic                  next_faultPin;

    // Limit code to a level in half-volt steps.
    function automatic logic [7:0] supplyLevel(input logic [2:0] code,
                                               input logic [7:0] base,
                                               input logic [7:0] step);
        return 8'(base + 8'(code) * step);
    endfunction

    // Bridge reaction for a lock-limit action code.
    function automatic bridge_t lockAction(input logic [3:0] mode);
        unique case (mode)
            LOCK_LATCH_HS, LOCK_RETRY_HS: lockAction = BR_HS;
            LOCK_LATCH_LS, LOCK_RETRY_LS: lockAction = BR_LS;
            LOCK_LATCH_HIZ0, LOCK_LATCH_HIZ1,
            LOCK_RETRY_HIZ0, LOCK_RETRY_HIZ1: lockAction = BR_HIZ;
            default: lockAction = BR_DRIVE;
        endcase
    endfunction

    // The tickle comes from the host pin, so it is synchronised first.
    assign next_tickleSync = {tickleSync[0], hostWatchdogTickle};
    assign tickleEdge      = tickleSync[1] && !tickleLast;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tickleSync <= 2'h0;
            tickleLast <= 1'b0;
        end else begin
            tickleSync <= next_tickleSync;
            tickleLast <= tickleSync[1];
        end
    end

    // One ramp timer, one watchdog timer and one shared retry timer.
    fault_timer #(.LIMIT(IPD_TIMEOUT_CYCLES)) ipdTimer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (positionDetectRampUp || positionDetectRampDown),
        .restart (1'b0),
        .expired (ipdExpired)
    );

    fault_timer #(.LIMIT(WDT_CYCLES)) wdtTimer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (hostWatchdogEnable),
        .restart (tickleEdge),
        .expired (wdtExpired)
    );

    // Retrying faults share one timer; a late arrival may retry early.
    fault_timer #(.LIMIT(LOCK_RETRY_CYCLES)) retryTimer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (|(engaged & retryMask)),
        .restart (1'b0),
        .expired (retryExpired)
    );

    assign upperLevel = supplyLevel(supplyUpperLimit, OVER_BASE, OVER_STEP);
    assign lowerLevel = supplyLevel(supplyLowerLimit, UNDER_BASE, UNDER_STEP);

    // Detection, enables, recovery kind and reaction of every fault.
    always_comb begin
        cond      = '0;
        trig      = '0;
        recovered = '0;
        retryMask = '0;
        autoMask  = '0;
        for (int i = 0; i < NUM_FAULTS; i++) begin
            act[i] = BR_HIZ;
        end
        cond[F_LOCK] = sensedCurrentVoltage > softLockCurrentThreshold;
        trig[F_LOCK] = cond[F_LOCK] &&
            !(softLockLimitAction[3] && softLockLimitAction[0]);
        act[F_LOCK] = lockAction(softLockLimitAction);
        retryMask[F_LOCK] = softLockLimitAction[2] &&
            !softLockLimitAction[3];
        cond[F_IPD_UP]   = ipdExpired && positionDetectRampUp;
        cond[F_IPD_DOWN] = ipdExpired && !positionDetectRampUp;
        trig[F_IPD_UP]   = cond[F_IPD_UP] &&
            positionDetectTimeoutEnable;
        trig[F_IPD_DOWN] = cond[F_IPD_DOWN] && positionDetectTimeoutEnable;
        cond[F_IPD_RATE] = positionDetectPulseStart &&
            !positionDetectCurrentDecayed;
        trig[F_IPD_RATE] = cond[F_IPD_RATE] &&
            positionDetectRateEnable;
        retryMask[F_IPD_UP]   = 1'b1;
        retryMask[F_IPD_DOWN] = 1'b1;
        retryMask[F_IPD_RATE] = 1'b1;
        cond[F_MEAS_TO]  = measureRlActive && measureRlTimeout;
        cond[F_MEAS_EMF] = measureBackemfActive &&
            (backemfLevel < stationaryDetectThreshold);
        trig[F_MEAS_TO]  = cond[F_MEAS_TO];
        trig[F_MEAS_EMF] = cond[F_MEAS_EMF];
        cond[F_OVER] = (supplyUpperLimit != SUPPLY_CODE_OFF) &&
            (supplyVoltage > upperLevel);
        trig[F_OVER] = cond[F_OVER];
        recovered[F_OVER] = supplyVoltage < upperLevel - OVER_HYST;
        autoMask[F_OVER]  = supplyOverRecoveryMode;
        cond[F_UNDER] = (supplyLowerLimit != SUPPLY_CODE_OFF) &&
            (supplyVoltage < lowerLevel);
        trig[F_UNDER] = cond[F_UNDER];
        recovered[F_UNDER] = supplyVoltage >
            lowerLevel + UNDER_HYST;
        autoMask[F_UNDER]  = supplyUnderRecoveryMode;
        cond[F_WDT] = wdtExpired;
        trig[F_WDT] = wdtExpired && hostWatchdogEnable;
        act[F_WDT]  = hostWatchdogAction ? BR_HIZ : BR_DRIVE;
    end

    // A fault stays engaged until its own recovery; a new trigger wins.
    always_comb begin
        next_bridgeMode = BR_DRIVE;
        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (retryMask[i]) begin
                release_[i] = retryExpired;
            end else if (autoMask[i]) begin
                release_[i] = recovered[i];
            end else begin
                release_[i] = faultClearCommand && !cond[i];
            end
        end
        next_engaged = trig | (engaged & ~release_);
        next_status  = trig | (controllerFaultStatus &
                       {NUM_FAULTS{!faultClearCommand}});
        // Hi-Z outranks a low-side brake, which outranks a high-side one.
        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (engaged[i] && act[i] == BR_HIZ) begin
                next_bridgeMode = BR_HIZ;
            end else if (engaged[i] && act[i] == BR_LS &&
                         next_bridgeMode != BR_HIZ) begin
                next_bridgeMode = BR_LS;
            end else if (engaged[i] && act[i] == BR_HS &&
                         next_bridgeMode == BR_DRIVE) begin
                next_bridgeMode = BR_HS;
            end
        end
        next_faultPin = !(|engaged);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            engaged               <= '0;
            controllerFaultStatus <= '0;
            bridgeMode            <= BR_DRIVE;
            faultPinLowActive     <= 1'b1;
        end else begin
            engaged               <= next_engaged;
            controllerFaultStatus <= next_status;
            bridgeMode            <= next_bridgeMode;
            faultPinLowActive     <= next_faultPin;
        end
    end

    sequence lockTrip(logic [3:0] code);
        trig[F_LOCK] && softLockLimitAction == code;
    endsequence

    sequence settleTwo;
        ##2 1'b1;
    endsequence

    statusSet_a: assert property (@(posedge ref_clk) disable iff (reset)
        (|trig) |=> ((controllerFaultStatus & $past(trig)) == $past(trig)))
        else $error("Fault status bit not set after trigger.");

    pinLow_a: assert property (@(posedge ref_clk) disable iff (reset)
        (|engaged) |=> !faultPinLowActive)
        else $error("Fault pin not low while a fault is engaged.");

    lockLatchHiz_a: assert property (@(posedge ref_clk) disable iff (reset)
        lockTrip(LOCK_LATCH_HIZ0) |-> settleTwo ##0 bridgeMode == BR_HIZ)
        else $error("Latched lock fault did not tri-state.");

    lockRetryHs_a: assert property (@(posedge ref_clk) disable iff (reset)
        lockTrip(LOCK_RETRY_HS) ##1 (engaged == (1 << F_LOCK))
        |=> bridgeMode == BR_HS)
        else $error("Retrying lock fault did not brake high side.");

    lockIgnore_a: assert property (@(posedge ref_clk) disable iff (reset)
        (softLockLimitAction[3] && softLockLimitAction[0]) |-> !trig[F_LOCK])
        else $error("Ignored lock code still tripped.");

    ipdOff_a: assert property (@(posedge ref_clk) disable iff (reset)
        !positionDetectTimeoutEnable |-> !(trig[F_IPD_UP] || trig[F_IPD_DOWN]))
        else $error("Disabled ramp timeout still tripped.");

    rateHiz_a: assert property (@(posedge ref_clk) disable iff (reset)
        (positionDetectRateEnable && cond[F_IPD_RATE])
        |=> controllerFaultStatus[F_IPD_RATE] ##1 bridgeMode == BR_HIZ)
        else $error("Rate fault did not report and tri-state.");

    measHold_a: assert property (@(posedge ref_clk) disable iff (reset)
        (engaged[F_MEAS_TO] && !faultClearCommand) |=> engaged[F_MEAS_TO])
        else $error("Measurement fault released without clear.");

    overAuto_a: assert property (@(posedge ref_clk) disable iff (reset)
        (engaged[F_OVER] && supplyOverRecoveryMode && recovered[F_OVER])
        |=> !engaged[F_OVER])
        else $error("Overvoltage did not recover below hysteresis.");

    underAuto_a: assert property (@(posedge ref_clk) disable iff (reset)
        (engaged[F_UNDER] && supplyUnderRecoveryMode && recovered[F_UNDER])
        |=> !engaged[F_UNDER])
        else $error("Undervoltage did not recover above hysteresis.");

    wdtHiz_a: assert property (@(posedge ref_clk) disable iff (reset)
        (trig[F_WDT] && hostWatchdogAction) |-> ##2 bridgeMode == BR_HIZ)
        else $error("Watchdog fault did not tri-state.");

    latchHold_a: assert property (@(posedge ref_clk) disable iff (reset)
        (engaged[F_LOCK] && !retryMask[F_LOCK] && !faultClearCommand)
        |=> engaged[F_LOCK])
        else $error("Latched lock fault released without clear.");

endmodule

// [rtl/fault_response_pkg.sv]
package fault_response_pkg;

    // Timing base: the single system clock.
    localparam longint CLK_HZ          = 10_000_000;
    localparam int     TIMER_W         = 24;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 24'h00_0001;

    // Printed and chosen times, in milliseconds.
    localparam int     IPD_TIMEOUT_MS  = 500;
    localparam int     LOCK_RETRY_MS   = 1000;
    localparam int     WDT_INTERVAL_MS = 1000;

    // Fault slots, shared by the status word and the internal vectors.
    localparam int NUM_FAULTS = 9;
    localparam int F_LOCK     = 0;
    localparam int F_IPD_UP   = 1;
    localparam int F_IPD_DOWN = 2;
    localparam int F_IPD_RATE = 3;
    localparam int F_MEAS_TO  = 4;
    localparam int F_MEAS_EMF = 5;
    localparam int F_OVER     = 6;
    localparam int F_UNDER    = 7;
    localparam int F_WDT      = 8;

    // Lock-limit action codes.
    localparam logic [3:0] LOCK_LATCH_HIZ0 = 4'h0;
    localparam logic [3:0] LOCK_LATCH_HIZ1 = 4'h1;
    localparam logic [3:0] LOCK_LATCH_HS   = 4'h2;
    localparam logic [3:0] LOCK_LATCH_LS   = 4'h3;
    localparam logic [3:0] LOCK_RETRY_HIZ0 = 4'h4;
    localparam logic [3:0] LOCK_RETRY_HIZ1 = 4'h5;
    localparam logic [3:0] LOCK_RETRY_HS   = 4'h6;
    localparam logic [3:0] LOCK_RETRY_LS   = 4'h7;
    localparam logic [3:0] LOCK_REPORT     = 4'h8;

    // Supply levels are in 0.5 V steps; limit codes map linearly.
    localparam logic [2:0] SUPPLY_CODE_OFF = 3'h0;
    localparam logic [7:0] OVER_BASE       = 8'h28;
    localparam logic [7:0] OVER_STEP       = 8'h0A;
    localparam logic [7:0] UNDER_BASE      = 8'h08;
    localparam logic [7:0] UNDER_STEP      = 8'h04;
    localparam logic [7:0] OVER_HYST       = 8'h02;
    localparam logic [7:0] UNDER_HYST      = 8'h01;

    typedef enum logic [1:0] {
        BR_DRIVE = 2'b00,
        BR_HIZ   = 2'b01,
        BR_HS    = 2'b10,
        BR_LS    = 2'b11
    } bridge_t;

    // Least time, so the count rounds up.
    function automatic logic [TIMER_W-1:0] msToCycles(input int ms);
        longint cycles;
        cycles = (longint'(ms) * CLK_HZ + 999) / 1000;
        return TIMER_W'(cycles);
    endfunction

endpackage

// [rtl/fault_timer.sv]
`timescale 1ns/1ns

// Counts while run is high; restart or a drop of run starts it over.
module fault_timer import fault_response_pkg::*; #(
    parameter logic [TIMER_W-1:0] LIMIT = TIMER_ONE
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);

    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] next_count;

    // The strobe is combinational so the owner acts in the same cycle.
    assign expired = run && !restart && (count == LIMIT - TIMER_ONE);

    // Wrap to zero on expiry so a held run gives a periodic strobe.
    always_comb begin
        if (!run || restart || expired) begin
            next_count = '0;
        end else begin
            next_count = count + TIMER_ONE;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// [test/host_model.sv]
`timescale 1ns/1ns

// Host controller: tickles the watchdog pin once every tickleGap cycles.
// A gap of zero stops tickling, which is how a missed tickle is made.
module host_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [5:0] tickleGap,
    output logic            hostWatchdogTickle
);
    logic [5:0] count;
    logic [5:0] next_count;
    logic       next_tickle;

    // The gap must stay under the watchdog interval less the sync delay.
    always_comb begin
        next_count = (count + 6'h01 >= tickleGap) ? 6'h00 : count + 6'h01;
        next_tickle = (tickleGap != 6'h00) && (count < (tickleGap >> 1));
    end

    // Registered so the pin changes just after a clock edge.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count <= 6'h00;
            hostWatchdogTickle <= 1'b0;
        end else begin
            count <= next_count;
            hostWatchdogTickle <= next_tickle;
        end
    end
endmodule

// [test/fault_response_test.sv]
`timescale 1ns/1ns

module fault_response_test import fault_response_pkg::*;;
    // Short counts keep the run brief; the long waits derive from them.
    localparam logic [TIMER_W-1:0] TO_C    = 24'h00_0014;
    localparam logic [TIMER_W-1:0] RETRY_C = 24'h00_001E;
    localparam logic [TIMER_W-1:0] WDT_C   = 24'h00_0028;
    localparam int                 WAIT_C  = int'(RETRY_C) + 10;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] sensedCurrentVoltage = 12'h100;
    logic [11:0] softLockCurrentThreshold = 12'h800;
    logic [3:0] softLockLimitAction = 4'h0;
    logic positionDetectRampUp = 1'b0;
    logic positionDetectRampDown = 1'b0;
    logic positionDetectTimeoutEnable = 1'b0;
    logic positionDetectPulseStart = 1'b0;
    logic positionDetectCurrentDecayed = 1'b1;
    logic positionDetectRateEnable = 1'b0;
    logic measureRlActive = 1'b0;
    logic measureRlTimeout = 1'b0;
    logic measureBackemfActive = 1'b0;
    logic [11:0] backemfLevel = 12'h400;
    logic [11:0] stationaryDetectThreshold = 12'h200;
    logic [7:0] supplyVoltage = 8'h20;
    logic [2:0] supplyUpperLimit = 3'h1;
    logic supplyOverRecoveryMode = 1'b0;
    logic [2:0] supplyLowerLimit = 3'h1;
    logic supplyUnderRecoveryMode = 1'b0;
    logic hostWatchdogEnable = 1'b0;
    logic hostWatchdogAction = 1'b0;
    logic hostWatchdogTickle;
    logic faultClearCommand = 1'b0;
    logic [5:0] tickleGap = 6'h00;
    logic faultPinLowActive;
    bridge_t bridgeMode;
    logic [NUM_FAULTS-1:0] controllerFaultStatus;
    int nMismatch = 0;
    int checksDone = 0;

    // Free-running 10 MHz clock.
    always #50 ref_clk = ~ref_clk;

    fault_response #(
        .IPD_TIMEOUT_CYCLES(TO_C), .LOCK_RETRY_CYCLES(RETRY_C),
        .WDT_CYCLES(WDT_C)
    ) dut_u (
        .ref_clk, .reset, .sensedCurrentVoltage, .softLockCurrentThreshold,
        .softLockLimitAction, .positionDetectRampUp, .positionDetectRampDown,
        .positionDetectTimeoutEnable, .positionDetectPulseStart,
        .positionDetectCurrentDecayed, .positionDetectRateEnable,
        .measureRlActive, .measureRlTimeout, .measureBackemfActive,
        .backemfLevel, .stationaryDetectThreshold, .supplyVoltage,
        .supplyUpperLimit, .supplyOverRecoveryMode, .supplyLowerLimit,
        .supplyUnderRecoveryMode, .hostWatchdogEnable, .hostWatchdogAction,
        .hostWatchdogTickle, .faultClearCommand, .faultPinLowActive,
        .bridgeMode, .controllerFaultStatus
    );

    host_model host_u (.ref_clk, .reset, .tickleGap, .hostWatchdogTickle);

    // Inputs move on the falling edge, away from the sampling edge.
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Pin, bridge state and status word are compared as one value.
    task automatic check_outputs(input logic pin, input bridge_t br,
                                 input logic [8:0] st);
        logic [11:0] got;
        logic [11:0] exp;
        got = {faultPinLowActive, bridgeMode, controllerFaultStatus};
        exp = {pin, br, st};
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One clear cycle, then time for the release to reach the outputs.
    task automatic clear_fault();
        faultClearCommand = 1'b1;
        tick(1);
        faultClearCommand = 1'b0;
        tick(3);
    endtask

    // A retried fault releases by itself; its status bit stays sticky.
    task automatic after_retry(input logic [8:0] st);
        tick(WAIT_C);
        check_outputs(1'b1, BR_DRIVE, st);
        clear_fault();
        check_outputs(1'b1, BR_DRIVE, 9'h000);
    endtask

    // A latched fault outlasts its cause until the clear command.
    task automatic expect_latched(input logic pin, input bridge_t br,
                                  input logic [8:0] st);
        tick(WAIT_C);
        check_outputs(pin, br, st);
        clear_fault();
        check_outputs(1'b1, BR_DRIVE, 9'h000);
    endtask

    // Expected bridge reaction for a lock action code.
    function automatic bridge_t lock_bridge(input logic [3:0] code);
        if (code[3]) return BR_DRIVE;
        case (code[1:0])
            2'b10: return BR_HS;
            2'b11: return BR_LS;
            default: return BR_HIZ;
        endcase
    endfunction

    task automatic lock_case(input logic [3:0] code);
        logic hit;
        logic [8:0] st;
        hit = !(code[3] && code[0]);
        st = {8'h00, hit};
        softLockLimitAction = code;
        sensedCurrentVoltage = 12'h900;
        tick(3);
        check_outputs(!hit, lock_bridge(code), st);
        clear_fault();
        check_outputs(!hit, lock_bridge(code), st);
        sensedCurrentVoltage = 12'h100;
        if (code[3:2] == 2'b01) begin
            after_retry(st);
        end else begin
            expect_latched(!hit, lock_bridge(code), st);
        end
    endtask

    task automatic ramp_case(input logic up, input logic en);
        logic [8:0] st;
        st = en ? (up ? 9'h002 : 9'h004) : 9'h000;
        positionDetectTimeoutEnable = en;
        positionDetectRampUp = up;
        positionDetectRampDown = !up;
        tick(int'(TO_C) - 4);
        check_outputs(1'b1, BR_DRIVE, 9'h000);
        tick(8);
        check_outputs(!en, en ? BR_HIZ : BR_DRIVE, st);
        positionDetectRampUp = 1'b0;
        positionDetectRampDown = 1'b0;
        after_retry(st);
    endtask

    task automatic rate_case(input logic en, input logic decayed);
        logic hit;
        hit = en && !decayed;
        positionDetectRateEnable = en;
        positionDetectCurrentDecayed = decayed;
        positionDetectPulseStart = 1'b1;
        tick(1);
        positionDetectPulseStart = 1'b0;
        tick(2);
        check_outputs(!hit, hit ? BR_HIZ : BR_DRIVE, {5'h00, hit, 3'h0});
        positionDetectCurrentDecayed = 1'b1;
        after_retry({5'h00, hit, 3'h0});
    endtask

    // Over level is 0x32, under level 0x0C, in half-volt units.
    task automatic supply_case(input logic over, input logic mode);
        logic [8:0] st;
        st = over ? 9'h040 : 9'h080;
        supplyOverRecoveryMode = mode;
        supplyUnderRecoveryMode = mode;
        supplyVoltage = over ? 8'h33 : 8'h0B;
        tick(3);
        check_outputs(1'b0, BR_HIZ, st);
        supplyVoltage = over ? 8'h30 : 8'h0D;
        tick(3);
        check_outputs(1'b0, BR_HIZ, st);
        supplyVoltage = over ? 8'h2F : 8'h0E;
        if (mode) begin
            tick(3);
            check_outputs(1'b1, BR_DRIVE, st);
            clear_fault();
        end else begin
            expect_latched(1'b0, BR_HIZ, st);
        end
        supplyVoltage = 8'h20;
    endtask

    task automatic wdt_case(input logic act);
        hostWatchdogAction = act;
        tickleGap = 6'h10;
        hostWatchdogEnable = 1'b1;
        tick(int'(WDT_C) * 3);
        check_outputs(1'b1, BR_DRIVE, 9'h000);
        tickleGap = 6'h00;
        tick(int'(WDT_C) + 10);
        check_outputs(1'b0, act ? BR_HIZ : BR_DRIVE, 9'h100);
        hostWatchdogEnable = 1'b0;
        expect_latched(1'b0, act ? BR_HIZ : BR_DRIVE, 9'h100);
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The tests need about 1800 cycles; a hang is cut at 20000.
    initial begin
        #(100 * 20000);
        nMismatch++;
        final_report();
    end

    // Main sequence.
    initial begin
        tick(16);
        check_outputs(1'b1, BR_DRIVE, 9'h000);
        reset = 1'b0;
        tick(2);
        for (int c = 0; c < 16; c++) begin
            lock_case(4'(c));
        end
        ramp_case(1'b1, 1'b1);
        ramp_case(1'b0, 1'b1);
        ramp_case(1'b1, 1'b0);
        rate_case(1'b1, 1'b0);
        rate_case(1'b1, 1'b1);
        rate_case(1'b0, 1'b0);
        measureRlActive = 1'b1;
        measureRlTimeout = 1'b1;
        tick(1);
        measureRlTimeout = 1'b0;
        measureRlActive = 1'b0;
        expect_latched(1'b0, BR_HIZ, 9'h010);
        measureBackemfActive = 1'b1;
        backemfLevel = 12'h100;
        tick(3);
        clear_fault();
        check_outputs(1'b0, BR_HIZ, 9'h020);
        measureBackemfActive = 1'b0;
        backemfLevel = 12'h400;
        expect_latched(1'b0, BR_HIZ, 9'h020);
        for (int k = 0; k < 4; k++) begin
            supply_case(k[1], k[0]);
        end
        supplyUpperLimit = 3'h0;
        supplyLowerLimit = 3'h0;
        supplyVoltage = 8'hFF;
        tick(3);
        check_outputs(1'b1, BR_DRIVE, 9'h000);
        supplyVoltage = 8'h00;
        tick(3);
        check_outputs(1'b1, BR_DRIVE, 9'h000);
        supplyVoltage = 8'h20;
        wdt_case(1'b1);
        wdt_case(1'b0);
        final_report();
    end
endmodule
